//--- hw/pwcb_regs.vh
// constants for the pixel window crop and binning block
// How it works
// - column 0 and row 0 sit at the upper-left array corner.
// - pixels outside the window are dropped, inside ones forwarded.
// - column start is first window column; width is columns per line.
// - row start is first window row; height is rows per frame.
// - monochrome builds accept any window value in steps of one.
// - colour builds force window values even, steps of two.
// - during continuous capture only offsets change; size writes refused.
// - after reset window covers full array or a fixed smaller default.
// - summation exists only on monochrome builds.
// - vertical summation adds two, three or four lines per pixel.
// - horizontal summation adds two, three or four columns per pixel.
// - factor one disables summation; two to four select it.
// - both directions sum at once with independent factors.
// - effective array size is physical size over factor, truncated.
// - window values count summed columns and lines when summing.
// - vertical summation lowers the allowed minimum gain.
// - a shorter window height ends frame readout earlier.
`ifndef PWCB_REGS_VH
`define PWCB_REGS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define PWCB_OFS_CTRL 12'h000
`define PWCB_OFS_COL_START 12'h004
`define PWCB_OFS_ROW_START 12'h008
`define PWCB_OFS_WIDTH 12'h00C
`define PWCB_OFS_HEIGHT 12'h010
`define PWCB_OFS_BIN 12'h014
`define PWCB_OFS_STATUS 12'h018
`define PWCB_OFS_EFF_DIM 12'h01C

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PWCB_CTRL_CAPTURE 0
`define PWCB_BIN_V_LSB 0
`define PWCB_BIN_H_LSB 4
`define PWCB_STAT_FRAME 0
`define PWCB_STAT_GAIN 1
`define PWCB_STAT_COLOR 2
`define PWCB_EFF_ROWS_LSB 16

// ------------------------------------------------------------
// array size, reset values and limits
// ------------------------------------------------------------
`define PWCB_ARRAY_COLS 12'd659
`define PWCB_ARRAY_ROWS 12'd494
`define PWCB_BIN_OFF 3'd1
`define PWCB_BIN_MAX 3'd4
`define PWCB_MEM_DEPTH 1024

`endif

//--- hw/pwcb_line_mem.v
// line store for partial vertical sums, one word per summed column
`timescale 1ns/1ps
`include "pwcb_regs.vh"
module pwcb_line_mem (
  // clock
  input wire clk,
  // write side
  input wire wr_en,
  input wire [9:0] wr_addr,
  input wire [15:0] wr_data,
  // read side
  input wire [9:0] rd_addr,
  output wire [15:0] rd_data
);

reg [15:0] mem [0:`PWCB_MEM_DEPTH-1];

always @(posedge clk) begin
  if (wr_en) begin
    mem[wr_addr] <= wr_data;
  end
end

assign rd_data = mem[rd_addr];

endmodule // pwcb_line_mem

//--- hw/pwcb_top.v
// window crop and pixel summation with apb registers
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "pwcb_regs.vh"
module pwcb_top #(
  parameter IS_COLOR = 0,
  parameter [11:0] DEF_WIDTH = `PWCB_ARRAY_COLS,
  parameter [11:0] DEF_HEIGHT = `PWCB_ARRAY_ROWS
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // pixel stream from readout
  input wire pix_valid,
  input wire pix_sof,
  input wire pix_sol,
  input wire [11:0] pix_data,
  // pixel stream to transmission path
  output reg out_valid,
  output reg out_sof,
  output reg out_sol,
  output reg out_eof,
  output reg [15:0] out_data,
  // gain control side
  output reg min_gain_lowered
);

// ------------------------------------------------------------
// reset release
// ------------------------------------------------------------
reg rst_s1;
reg rst_n;
always @(posedge clk or negedge arst_n) begin
  if (!arst_n) begin
    rst_s1 <= 1'b0;
    rst_n <= 1'b0;
  end else begin
    rst_s1 <= 1'b1;
    rst_n <= rst_s1;
  end
end

// ------------------------------------------------------------
// configuration registers
// ------------------------------------------------------------
reg capture_on;
reg [11:0] window_col_start_param;
reg [11:0] window_row_start_param;
reg [11:0] win_width;
reg [11:0] win_height;
reg [2:0] bin_v;
reg [2:0] bin_h;
reg frame_active;
reg [11:0] eff_cols;
reg [11:0] eff_rows;

wire acc_phase = psel & penable & ~pready;
wire wr_fire = psel & penable & pready & pwrite;
wire [11:0] wval = IS_COLOR ? {pwdata[11:1], 1'b0} : pwdata[11:0];
wire [2:0] wbin_v = pwdata[`PWCB_BIN_V_LSB+2:`PWCB_BIN_V_LSB];
wire [2:0] wbin_h = pwdata[`PWCB_BIN_H_LSB+2:`PWCB_BIN_H_LSB];
wire bin_ok = (wbin_v >= `PWCB_BIN_OFF) && (wbin_v <= `PWCB_BIN_MAX) &&
              (wbin_h >= `PWCB_BIN_OFF) && (wbin_h <= `PWCB_BIN_MAX);

reg map_hit;
reg refuse;
reg [31:0] next_rdata;
always @* begin
  map_hit = 1'b1;
  refuse = 1'b0;
  next_rdata = 32'h0000_0000;
  case (paddr)
    `PWCB_OFS_CTRL: next_rdata[`PWCB_CTRL_CAPTURE] = capture_on;
    `PWCB_OFS_COL_START: next_rdata[11:0] = window_col_start_param;
    `PWCB_OFS_ROW_START: next_rdata[11:0] = window_row_start_param;
    `PWCB_OFS_WIDTH: begin
      next_rdata[11:0] = win_width;
      refuse = pwrite & capture_on;
    end
    `PWCB_OFS_HEIGHT: begin
      next_rdata[11:0] = win_height;
      refuse = pwrite & capture_on;
    end
    `PWCB_OFS_BIN: begin
      next_rdata[`PWCB_BIN_V_LSB+2:`PWCB_BIN_V_LSB] = bin_v;
      next_rdata[`PWCB_BIN_H_LSB+2:`PWCB_BIN_H_LSB] = bin_h;
      refuse = pwrite & (~bin_ok | capture_on);
    end
    `PWCB_OFS_STATUS: begin
      next_rdata[`PWCB_STAT_FRAME] = frame_active;
      next_rdata[`PWCB_STAT_GAIN] = min_gain_lowered;
      next_rdata[`PWCB_STAT_COLOR] = (IS_COLOR != 0);
    end
    `PWCB_OFS_EFF_DIM: begin
      next_rdata[11:0] = eff_cols;
      next_rdata[`PWCB_EFF_ROWS_LSB+11:`PWCB_EFF_ROWS_LSB] = eff_rows;
    end
    default: map_hit = 1'b0;
  endcase
end

// one wait state: answer registered in the first access cycle
always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    pready <= 1'b0;
    pslverr <= 1'b0;
    prdata <= 32'h0000_0000;
  end else begin
    pready <= acc_phase;
    pslverr <= acc_phase & (~map_hit | refuse);
    if (acc_phase) begin
      prdata <= pwrite ? 32'h0000_0000 : next_rdata;
    end
  end
end

always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    capture_on <= 1'b0;
    window_col_start_param <= 12'h000;
    window_row_start_param <= 12'h000;
    win_width <= DEF_WIDTH;
    win_height <= DEF_HEIGHT;
    bin_v <= `PWCB_BIN_OFF;
    bin_h <= `PWCB_BIN_OFF;
  end else if (wr_fire && !pslverr) begin
    case (paddr)
      `PWCB_OFS_CTRL: capture_on <= pwdata[`PWCB_CTRL_CAPTURE];
      `PWCB_OFS_COL_START: window_col_start_param <= wval;
      `PWCB_OFS_ROW_START: window_row_start_param <= wval;
      `PWCB_OFS_WIDTH: win_width <= wval;
      `PWCB_OFS_HEIGHT: win_height <= wval;
      `PWCB_OFS_BIN: begin
        if (IS_COLOR == 0) begin
          bin_v <= wbin_v;
          bin_h <= wbin_h;
        end
      end
      default: capture_on <= capture_on;
    endcase
  end
end

// ------------------------------------------------------------
// effective array size and gain limit
// ------------------------------------------------------------
function [11:0] div_by;
  input [11:0] dim;
  input [2:0] f;
  begin
    case (f)
      3'd2: div_by = dim / 12'd2;
      3'd3: div_by = dim / 12'd3;
      3'd4: div_by = dim / 12'd4;
      default: div_by = dim;
    endcase
  end
endfunction

always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    eff_cols <= `PWCB_ARRAY_COLS;
    eff_rows <= `PWCB_ARRAY_ROWS;
    min_gain_lowered <= 1'b0;
  end else begin
    eff_cols <= div_by(`PWCB_ARRAY_COLS, bin_h);
    eff_rows <= div_by(`PWCB_ARRAY_ROWS, bin_v);
    min_gain_lowered <= (bin_v != `PWCB_BIN_OFF);
  end
end

// ------------------------------------------------------------
// frame config, size and factors taken at frame start
// ------------------------------------------------------------
reg [11:0] act_width;
reg [11:0] act_height;
reg [2:0] act_bv;
reg [2:0] act_bh;
wire fstart = pix_valid & pix_sof;
wire [11:0] a_w = fstart ? win_width : act_width;
wire [11:0] a_h = fstart ? win_height : act_height;
wire [2:0] a_bv = fstart ? bin_v : act_bv;
wire [2:0] a_bh = fstart ? bin_h : act_bh;
wire [11:0] a_cs = window_col_start_param;
wire [11:0] a_rs = window_row_start_param;

always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    act_width <= DEF_WIDTH;
    act_height <= DEF_HEIGHT;
    act_bv <= `PWCB_BIN_OFF;
    act_bh <= `PWCB_BIN_OFF;
  end else if (fstart) begin
    act_width <= win_width;
    act_height <= win_height;
    act_bv <= bin_v;
    act_bh <= bin_h;
  end
end

// ------------------------------------------------------------
// position counters in summed units
// ------------------------------------------------------------
reg [2:0] hph;
reg [2:0] vph;
reg [11:0] vcol;
reg [11:0] vrow;
reg [15:0] hacc;
wire sol = pix_sol | pix_sof;
wire last_vph = (vph == a_bv - 3'd1);
wire [2:0] c_hph = sol ? 3'd0 : hph;
wire [11:0] c_col = sol ? 12'h000 : vcol;
wire [2:0] c_vph = pix_sof ? 3'd0 : (pix_sol ? (last_vph ? 3'd0 : vph + 3'd1) : vph);
wire [11:0] c_row = pix_sof ? 12'h000 : ((pix_sol && last_vph) ? vrow + 12'd1 : vrow);
wire [15:0] c_acc = (c_hph == 3'd0 ? 16'h0000 : hacc) + {4'h0, pix_data};
wire grp_done = (c_hph == a_bh - 3'd1);
wire vdone = (c_vph == a_bv - 3'd1);

always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    hph <= 3'd0;
    vph <= 3'd0;
    vcol <= 12'h000;
    vrow <= 12'h000;
    hacc <= 16'h0000;
  end else if (pix_valid) begin
    hph <= grp_done ? 3'd0 : c_hph + 3'd1;
    vcol <= grp_done ? c_col + 12'd1 : c_col;
    vph <= c_vph;
    vrow <= c_row;
    hacc <= c_acc;
  end
end

// ------------------------------------------------------------
// vertical partial sums
// ------------------------------------------------------------
wire [15:0] mem_rd;
wire [15:0] vsum = (c_vph == 3'd0 ? 16'h0000 : mem_rd) + c_acc;
wire mem_we = pix_valid & grp_done & ~vdone;

pwcb_line_mem i_pwcb_line_mem (
  .clk(clk),
  .wr_en(mem_we),
  .wr_addr(c_col[9:0]),
  .wr_data(vsum),
  .rd_addr(c_col[9:0]),
  .rd_data(mem_rd)
);

// ------------------------------------------------------------
// window gate and output stage
// ------------------------------------------------------------
wire [12:0] col_end = {1'b0, a_cs} + {1'b0, a_w};
wire [12:0] row_end = {1'b0, a_rs} + {1'b0, a_h};
wire in_col = (c_col >= a_cs) && ({1'b0, c_col} < col_end);
wire in_row = (c_row >= a_rs) && ({1'b0, c_row} < row_end);
wire emit = pix_valid & grp_done & vdone & in_col & in_row;
wire first_col = (c_col == a_cs);
wire first_row = (c_row == a_rs);
wire last_pix = ({1'b0, c_col} == col_end - 13'd1) && ({1'b0, c_row} == row_end - 13'd1);

always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    out_valid <= 1'b0;
    out_sof <= 1'b0;
    out_sol <= 1'b0;
    out_eof <= 1'b0;
    out_data <= 16'h0000;
  end else begin
    out_valid <= emit;
    out_sof <= emit & first_col & first_row;
    out_sol <= emit & first_col;
    out_eof <= emit & last_pix;
    if (emit) begin
      out_data <= vsum;
    end
  end
end

// frame busy from first pixel to last window pixel
always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    frame_active <= 1'b0;
  end else if (emit && last_pix) begin
    frame_active <= 1'b0;
  end else if (fstart) begin
    frame_active <= 1'b1;
  end
end

endmodule // pwcb_top

//--- tb/pwcb_top_chk.sv
// port checker for the window crop and summing block
`timescale 1ns/1ps
module pwcb_top_chk #(
  parameter IS_COLOR = 0
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // pixel streams
  input wire pix_valid,
  input wire out_valid,
  input wire out_sof,
  input wire out_sol,
  input wire out_eof,
  input wire min_gain_lowered
);
  // ----
  // properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire wr_done = pready && psel && pwrite;
  wire bin_wr = wr_done && paddr == 12'h014;
  chk_one_wait: assert property ($rose(penable) |-> !pready ##1 pready)
    else $error("apb answer not after one wait");
  chk_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  chk_wr_rdata: assert property (wr_done |-> prdata == 32'h0) else $error("read data on write");
  chk_unmapped_err: assert property (pready && paddr > 12'h01C |-> pslverr && prdata == 32'h0)
    else $error("unmapped access accepted");
  chk_bin_refused: assert property (bin_wr && IS_COLOR == 0 && (pwdata[2:0] == 3'h0 || pwdata[2:0] > 3'h4)
    |-> pslverr) else $error("bad factor accepted");
  chk_out_cause: assert property (out_valid |-> $past(pix_valid)) else $error("pixel without input");
  chk_sof_flags: assert property (out_sof |-> out_valid && out_sol) else $error("frame start flags");
  chk_eof_valid: assert property (out_eof |-> out_valid) else $error("frame end without pixel");
  chk_gain_source: assert property (!$stable(min_gain_lowered) |-> $past(bin_wr) || $past(bin_wr, 2))
    else $error("gain limit moved alone");
  chk_gain_lower: assert property (bin_wr && IS_COLOR == 0 && !pslverr && pwdata[2:0] == 3'h2
    |-> ##[1:2] min_gain_lowered)
    else $error("gain limit not lowered");
  cover property (out_sof);
  cover property (pslverr);
  cover property ($rose(min_gain_lowered));
endmodule // pwcb_top_chk

//--- tb/pwcb_pix_src.sv
// sensor readout model feeding raster frames
`timescale 1ns/1ps
module pwcb_pix_src (
  // clock
  input wire clk,
  // pixel stream
  output logic pix_valid,
  output logic pix_sof,
  output logic pix_sol,
  output logic [11:0] pix_data
);
  initial begin
    pix_valid = 1'b0;
    pix_sof = 1'b0;
    pix_sol = 1'b0;
    pix_data = 12'h000;
  end
  // raster from column 0 row 0, 1+gap idle cycles after each pixel when gap is nonzero, else only after each line
  task send_frame(input int cols, input int rows, input int gap);
    for (int r = 0; r < rows; r++) begin
      for (int c = 0; c < cols; c++) begin
        @(posedge clk);
        pix_valid <= 1'b1;
        pix_sof <= (r == 0 && c == 0);
        pix_sol <= (c == 0);
        pix_data <= 12'(r * 16 + c);
        if (gap > 0 || c == cols - 1) begin
          @(posedge clk);
          pix_valid <= 1'b0;
          pix_sof <= 1'b0;
          pix_sol <= 1'b0;
          pix_data <= ~pix_data;
          repeat (gap) @(posedge clk);
        end
      end
    end
  endtask
endmodule // pwcb_pix_src

//--- tb/pwcb_top_bench.sv
// bench for the window crop and summing block
`timescale 1ns/1ps
module pwcb_top_bench;
  logic clk, arst_n, psel, penable, pwrite, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, rdc;
  wire [31:0] prdata_c;
  wire pready_c, pslverr_c, out_valid_c, out_sof_c, out_sol_c, out_eof_c, min_gain_c;
  wire [15:0] out_data_c;
  int sols, cnt_c, sum_c;
  wire [31:0] prdata;
  wire pready, pslverr, pix_valid, pix_sof, pix_sol, out_valid, out_sof, out_sol, out_eof, min_gain_lowered;
  wire [11:0] pix_data;
  wire [15:0] out_data;
  logic [15:0] q[$];
  int sofs, eofs, miscompares, checks, cyc;
  pwcb_top i_pwcb_top (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pix_valid(pix_valid), .pix_sof(pix_sof), .pix_sol(pix_sol), .pix_data(pix_data),
    .out_valid(out_valid), .out_sof(out_sof), .out_sol(out_sol), .out_eof(out_eof),
    .out_data(out_data), .min_gain_lowered(min_gain_lowered));
  // colour build on the same bus and stream
  pwcb_top #(.IS_COLOR(1)) i_pwcb_top_color (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_c), .pready(pready_c), .pslverr(pslverr_c),
    .pix_valid(pix_valid), .pix_sof(pix_sof), .pix_sol(pix_sol), .pix_data(pix_data),
    .out_valid(out_valid_c), .out_sof(out_sof_c), .out_sol(out_sol_c), .out_eof(out_eof_c),
    .out_data(out_data_c), .min_gain_lowered(min_gain_c));
  pwcb_pix_src i_pwcb_pix_src (.clk(clk), .pix_valid(pix_valid), .pix_sof(pix_sof),
    .pix_sol(pix_sol), .pix_data(pix_data));
  // ----
  // clock, monitor, timeout
  // ----
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (out_valid === 1'b1) begin
      q.push_back(out_data);
      sofs += out_sof;
      sols += out_sol;
      eofs += out_eof;
    end
    if (out_valid_c === 1'b1) begin
      cnt_c++;
      sum_c += out_data_c;
    end
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run;
    end
  end
  // ----
  // tasks
  // ----
  task complete_run;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    rdc = prdata_c;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
    apb(1'b1, a, d);
    chk({31'h0, er}, {31'h0, ee});
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
    chk({31'h0, er}, {31'h0, ee});
  endtask
  task frame(input int c, input int r, input int g);
    q.delete();
    sofs = 0;
    sols = 0;
    eofs = 0;
    cnt_c = 0;
    sum_c = 0;
    i_pwcb_pix_src.send_frame(c, r, g);
    repeat (4) @(posedge clk);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rc(12'h00C, 32'h293, 1'b0);
    rc(12'h010, 32'h1EE, 1'b0);
    rc(12'h014, 32'h11, 1'b0);
    rc(12'h040, 32'h0, 1'b1);
    for (int f = 1; f <= 4; f++) begin
      wr(12'h014, {25'h0, 3'(f), 1'b0, 3'(f)}, 1'b0);
      rc(12'h01C, {4'h0, 12'(494 / f), 4'h0, 12'(659 / f)}, 1'b0);
    end
    wr(12'h014, 32'h5, 1'b1);
    rc(12'h014, 32'h44, 1'b0);
    chk(rdc, 32'h11);
    wr(12'h014, 32'h11, 1'b0);
    wr(12'h004, 32'h2, 1'b0);
    wr(12'h008, 32'h1, 1'b0);
    wr(12'h00C, 32'h3, 1'b0);
    wr(12'h010, 32'h2, 1'b0);
    for (int g = 0; g < 3; g += 2) begin
      frame(8, 4, g);
      chk(q.size(), 6);
      for (int i = 0; i < 6; i++)
        chk(q[i], (1 + i / 3) * 16 + 2 + i % 3);
      chk(sofs, 1);
      chk(eofs, 1);
      chk(sols, 2);
      chk(cnt_c, 4);
      chk(sum_c, 32'h2A);
    end
    rc(12'h018, 32'h0, 1'b0);
    wr(12'h004, 32'h0, 1'b0);
    wr(12'h008, 32'h0, 1'b0);
    wr(12'h00C, 32'h2, 1'b0);
    wr(12'h010, 32'h1, 1'b0);
    wr(12'h014, 32'h32, 1'b0);
    rc(12'h018, 32'h2, 1'b0);
    chk(min_gain_lowered, 1);
    frame(6, 2, 1);
    chk(q.size(), 2);
    chk(q[0], 32'h36);
    chk(q[1], 32'h48);
    chk(sols, 1);
    wr(12'h000, 32'h1, 1'b0);
    wr(12'h00C, 32'h5, 1'b1);
    wr(12'h004, 32'h1, 1'b0);
    rc(12'h00C, 32'h2, 1'b0);
    rc(12'h004, 32'h1, 1'b0);
    chk(rdc, 32'h0);
    wr(12'h000, 32'h0, 1'b0);
    complete_run;
  end
endmodule // pwcb_top_bench

bind pwcb_top pwcb_top_chk #(.IS_COLOR(IS_COLOR)) i_pwcb_top_chk (.*);
